// *** logic/cog_pkg.sv ***
// Purpose: shared constants and types of the complementary output block
// Assumes: 32-bit APB, one word per register
// Notes:   counts and offsets are referenced by name only
package cog_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ADDR_CTRL0      = 8'h00;
  localparam logic [7:0] ADDR_CTRL1      = 8'h04;
  localparam logic [7:0] ADDR_RISE_EN    = 8'h08;
  localparam logic [7:0] ADDR_RISE_MODE  = 8'h0c;
  localparam logic [7:0] ADDR_PHASE_RISE = 8'h10;
  localparam logic [7:0] ADDR_BLANK_RISE = 8'h14;
  localparam logic [7:0] ADDR_DB_RISE    = 8'h18;
  localparam logic [7:0] ADDR_DB_FALL    = 8'h1c;

  localparam logic [7:0] CTRL0_MASK = 8'hdf;
  localparam logic [7:0] CTRL1_MASK = 8'hcf;
  localparam logic [7:0] SRC_MASK   = 8'h7f;
  localparam logic [7:0] REG_RESET  = 8'h00;
  localparam int         REG_W      = 8;
  localparam int         INSTR_DIV  = 4;

  // ****************************************
  // encodings and carriers
  // ****************************************
  typedef enum logic [1:0] {
    CS_INSTR = 2'h0,
    CS_SYS   = 2'h1,
    CS_HFOSC = 2'h2,
    CS_RSVD  = 2'h3
  } clk_sel_t;

  typedef enum logic [2:0] {
    MD_STEER = 3'h0,
    MD_SYNC  = 3'h1,
    MD_FWD   = 3'h2,
    MD_REV   = 3'h3,
    MD_HALF  = 3'h4,
    MD_PP    = 3'h5
  } out_mode_t;

  typedef struct packed {
    logic      module_on;
    logic      buffer_load_request;
    logic      unused;
    clk_sel_t  clock_source_sel;
    out_mode_t output_mode_sel;
  } ctrl0_t;

  typedef struct packed {
    logic       rise_deadband_src;
    logic       fall_deadband_src;
    logic [1:0] unused;
    logic [3:0] polarity;
  } ctrl1_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PHASE,
    ST_RISE_DB,
    ST_ON,
    ST_FALL_DB
  } pwm_state_t;

endpackage : cog_pkg

// *** logic/cog_tick_gen.sv ***
// Purpose: generator clock tick from the selected source
// Assumes: hf_osc_tick is a pclk-synchronous one-cycle pulse
// Notes:   reserved select gives no ticks
`timescale 1ns/1ps
`default_nettype none
module cog_tick_gen
  import cog_pkg::*;
(
  input  wire logic     pclk,
  input  wire logic     presetn,
  input  wire logic     clk_en,
  input  wire clk_sel_t sel,
  input  wire logic     hf_osc_tick,
  output logic          tick
);

  logic [1:0] div;
  logic [1:0] next_div;
  logic       next_tick;

  always_comb
  begin
    next_div  = div + 2'h1;
    next_tick = 1'b0;
    case (sel)
      CS_INSTR: next_tick = (div == 2'(INSTR_DIV - 1));
      CS_SYS:   next_tick = 1'b1;
      CS_HFOSC: next_tick = hf_osc_tick;
      default:  next_tick = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div  <= 2'h0;
      tick <= 1'b0;
    end
    else if (clk_en)
    begin
      div  <= next_div;
      tick <= next_tick;
    end
  end

endmodule : cog_tick_gen
`default_nettype wire

// *** logic/cog_delay_counter.sv ***
// Purpose: loadable down-counter for phase, blanking and dead band
// Assumes: start wins over counting
// Notes:   done is a one-cycle pulse after the count has run out
`timescale 1ns/1ps
`default_nettype none
module cog_delay_counter #(
  parameter int W = 8
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         clk_en,
  input  wire logic         start,
  input  wire logic [W-1:0] load_val,
  input  wire logic         tick,
  output logic              busy,
  output logic              done
);

  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic         next_busy;
  logic         next_done;

  always_comb
  begin
    next_cnt  = cnt;
    next_busy = busy;
    next_done = 1'b0;
    if (start)
    begin
      next_cnt  = load_val;
      next_busy = 1'b1;
    end
    else if (busy && cnt == '0)
    begin
      next_busy = 1'b0;
      next_done = 1'b1;
    end
    else if (busy && tick)
      next_cnt = cnt - 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt  <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else if (clk_en)
    begin
      cnt  <= next_cnt;
      busy <= next_busy;
      done <= next_done;
    end
  end

endmodule : cog_delay_counter
`default_nettype wire

// *** logic/cog_core.sv ***
// Purpose: control registers and output sequencing of the generator
// Assumes: event sources and fall_event are synchronous to pclk
// Notes:   APB slave answers in the second access cycle
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module cog_core
  import cog_pkg::*;
#(
  parameter int CNT_W = 8,
  parameter int SRC_N = 7
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             clk_en,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic [SRC_N-1:0] event_src,
  input  wire logic             fall_event,
  input  wire logic             hf_osc_tick,
  output logic [3:0]            out_pins
);

  // ****************************************
  // registers
  // ****************************************
  ctrl0_t            ctrl0;
  ctrl0_t            next_ctrl0;
  ctrl1_t            ctrl1;
  ctrl1_t            next_ctrl1;
  logic [REG_W-1:0]  rise_src_en;
  logic [REG_W-1:0]  next_rise_src_en;
  logic [REG_W-1:0]  rise_src_mode;
  logic [REG_W-1:0]  next_rise_src_mode;
  logic [CNT_W-1:0]  phase_rise;
  logic [CNT_W-1:0]  next_phase_rise;
  logic [CNT_W-1:0]  blank_rise;
  logic [CNT_W-1:0]  next_blank_rise;
  logic [CNT_W-1:0]  rise_deadband_count;
  logic [CNT_W-1:0]  next_rise_deadband_count;
  logic [CNT_W-1:0]  fall_deadband_count;
  logic [CNT_W-1:0]  next_fall_deadband_count;
  logic [4*CNT_W-1:0] work;
  logic [4*CNT_W-1:0] next_work;
  logic [31:0]       next_prdata;
  logic              next_pready;
  logic              next_pslverr;
  logic              wr;
  logic              xfer;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= ADDR_DB_FALL);
  endfunction : mapped

  assign wr = psel && penable && pready && pwrite;

  always_comb
  begin
    next_ctrl0               = ctrl0;
    next_ctrl1               = ctrl1;
    next_rise_src_en         = rise_src_en;
    next_rise_src_mode       = rise_src_mode;
    next_phase_rise          = phase_rise;
    next_blank_rise          = blank_rise;
    next_rise_deadband_count = rise_deadband_count;
    next_fall_deadband_count = fall_deadband_count;
    next_pready  = psel && penable && !pready;
    next_pslverr = psel && penable && !pready && !mapped(paddr);
    next_prdata  = prdata;
    if (xfer)
      next_ctrl0.buffer_load_request = 1'b0;
    if (wr)
      case (paddr)
        ADDR_CTRL0:      next_ctrl0 = ctrl0_t'(pwdata[7:0] & CTRL0_MASK);
        ADDR_CTRL1:      next_ctrl1 = ctrl1_t'(pwdata[7:0] & CTRL1_MASK);
        ADDR_RISE_EN:    next_rise_src_en = pwdata[7:0] & SRC_MASK;
        ADDR_RISE_MODE:  next_rise_src_mode = pwdata[7:0] & SRC_MASK;
        ADDR_PHASE_RISE: next_phase_rise = pwdata[CNT_W-1:0];
        ADDR_BLANK_RISE: next_blank_rise = pwdata[CNT_W-1:0];
        ADDR_DB_RISE:    next_rise_deadband_count = pwdata[CNT_W-1:0];
        ADDR_DB_FALL:    next_fall_deadband_count = pwdata[CNT_W-1:0];
        default:         next_ctrl0 = next_ctrl0;
      endcase
    if (psel && !penable)
      case (paddr)
        ADDR_CTRL0:      next_prdata = {24'h0, ctrl0};
        ADDR_CTRL1:      next_prdata = {24'h0, ctrl1};
        ADDR_RISE_EN:    next_prdata = {24'h0, rise_src_en};
        ADDR_RISE_MODE:  next_prdata = {24'h0, rise_src_mode};
        ADDR_PHASE_RISE: next_prdata = 32'(phase_rise);
        ADDR_BLANK_RISE: next_prdata = 32'(blank_rise);
        ADDR_DB_RISE:    next_prdata = 32'(rise_deadband_count);
        ADDR_DB_FALL:    next_prdata = 32'(fall_deadband_count);
        default:         next_prdata = 32'h0;
      endcase
    if (!ctrl0.module_on || xfer)
      next_work = {next_phase_rise, next_blank_rise,
                   next_rise_deadband_count, next_fall_deadband_count};
    else
      next_work = work;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl0               <= ctrl0_t'(REG_RESET);
      ctrl1               <= ctrl1_t'(REG_RESET);
      rise_src_en         <= REG_RESET;
      rise_src_mode       <= REG_RESET;
      phase_rise          <= '0;
      blank_rise          <= '0;
      rise_deadband_count <= '0;
      fall_deadband_count <= '0;
      work                <= '0;
      prdata              <= 32'h0;
      pready              <= 1'b0;
      pslverr             <= 1'b0;
    end
    else if (clk_en)
    begin
      ctrl0               <= next_ctrl0;
      ctrl1               <= next_ctrl1;
      rise_src_en         <= next_rise_src_en;
      rise_src_mode       <= next_rise_src_mode;
      phase_rise          <= next_phase_rise;
      blank_rise          <= next_blank_rise;
      rise_deadband_count <= next_rise_deadband_count;
      fall_deadband_count <= next_fall_deadband_count;
      work                <= next_work;
      prdata              <= next_prdata;
      pready              <= next_pready;
      pslverr             <= next_pslverr;
    end
  end

  // ****************************************
  // timing sources and counters
  // ****************************************
  logic             gen_tick;
  logic             db_tick;
  logic             phase_busy;
  logic             phase_done;
  logic             blank_busy;
  logic             db_done;
  logic             db_start;
  logic [CNT_W-1:0] db_load;
  logic             rise_start;
  logic             fall_start;
  logic             edge_start;
  pwm_state_t       state;
  pwm_state_t       next_state;

  cog_tick_gen u_tick (
    .pclk        (pclk),
    .presetn     (presetn),
    .clk_en      (clk_en),
    .sel         (ctrl0.clock_source_sel),
    .hf_osc_tick (hf_osc_tick),
    .tick        (gen_tick)
  );

  // fast chain approximated by counting on pclk itself
  assign db_tick = (state == ST_FALL_DB) ?
                   (ctrl1.fall_deadband_src || gen_tick) :
                   (ctrl1.rise_deadband_src || gen_tick);
  assign db_start = rise_start || fall_start;
  assign db_load  = fall_start ? work[CNT_W-1:0] : work[2*CNT_W-1:CNT_W];

  cog_delay_counter #(.W(CNT_W)) u_phase (
    .pclk     (pclk),
    .presetn  (presetn),
    .clk_en   (clk_en),
    .start    (edge_start),
    .load_val (work[4*CNT_W-1:3*CNT_W]),
    .tick     (gen_tick),
    .busy     (phase_busy),
    .done     (phase_done)
  );

  cog_delay_counter #(.W(CNT_W)) u_blank (
    .pclk     (pclk),
    .presetn  (presetn),
    .clk_en   (clk_en),
    .start    (rise_start),
    .load_val (work[3*CNT_W-1:2*CNT_W]),
    .tick     (gen_tick),
    .busy     (blank_busy),
    .done     ()
  );

  cog_delay_counter #(.W(CNT_W)) u_db (
    .pclk     (pclk),
    .presetn  (presetn),
    .clk_en   (clk_en),
    .start    (db_start),
    .load_val (db_load),
    .tick     (db_tick),
    .busy     (),
    .done     (db_done)
  );

  // ****************************************
  // event detection and sequencing
  // ****************************************
  logic [SRC_N-1:0] src_q;
  logic             level_rise;
  logic             edge_rise;
  logic             pp_sel;
  logic             next_pp_sel;
  logic             prim;
  logic             comp;
  logic [3:0]       drive;
  logic [3:0]       next_out;

  assign level_rise = |(rise_src_en[SRC_N-1:0] & ~rise_src_mode[SRC_N-1:0]
                        & event_src);
  assign edge_rise  = |(rise_src_en[SRC_N-1:0] & rise_src_mode[SRC_N-1:0]
                        & event_src & ~src_q);
  assign xfer = ctrl0.module_on && ctrl0.buffer_load_request
                && state == ST_IDLE && (level_rise || edge_rise);
  assign edge_start = next_state == ST_PHASE && state != ST_PHASE;
  assign rise_start = next_state == ST_RISE_DB && state != ST_RISE_DB;
  assign fall_start = next_state == ST_FALL_DB && state != ST_FALL_DB;

  always_comb
  begin
    next_state  = state;
    next_pp_sel = pp_sel;
    case (state)
      ST_IDLE:
        if (level_rise)
          next_state = ST_RISE_DB;
        else if (edge_rise)
          next_state = ST_PHASE;
      ST_PHASE:
        if (phase_done)
          next_state = ST_RISE_DB;
      ST_RISE_DB:
        if (db_done)
        begin
          next_state  = ST_ON;
          next_pp_sel = !pp_sel;
        end
      ST_ON:
        if (fall_event && !blank_busy)
          next_state = ST_FALL_DB;
      ST_FALL_DB:
        if (db_done)
          next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
    if (!ctrl0.module_on)
      next_state = ST_IDLE;
  end

  always_comb
  begin
    prim  = ctrl0.module_on && state == ST_ON;
    comp  = ctrl0.module_on && state == ST_IDLE;
    drive = 4'h0;
    case (ctrl0.output_mode_sel)
      MD_STEER, MD_SYNC: drive = {4{prim}};
      MD_FWD:            drive = {prim, 1'b0, 1'b0, ctrl0.module_on};
      MD_REV:            drive = {1'b0, ctrl0.module_on, prim, 1'b0};
      MD_HALF:           drive = {comp, prim, comp, prim};
      MD_PP:             drive = {2'h0, prim && !pp_sel, prim && pp_sel};
      default:           drive = 4'h0;
    endcase
    next_out = drive ^ ctrl1.polarity;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state    <= ST_IDLE;
      src_q    <= '0;
      pp_sel   <= 1'b0;
      out_pins <= 4'h0;
    end
    else if (clk_en)
    begin
      state    <= next_state;
      src_q    <= event_src;
      pp_sel   <= next_pp_sel;
      out_pins <= next_out;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  chk_ctrl0_reserved: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && psel && !penable && paddr == ADDR_CTRL0) |=> prdata[5] == 1'b0)
    else $error("reserved control bit read as one");
  chk_off_idle: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && !ctrl0.module_on) |=> state == ST_IDLE)
    else $error("disabled generator left idle");
  chk_load_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && xfer && !(wr && paddr == ADDR_CTRL0))
    |=> !ctrl0.buffer_load_request)
    else $error("load request not cleared after transfer");
  chk_off_direct: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && !ctrl0.module_on) |=> work[CNT_W-1:0] == fall_deadband_count)
    else $error("working buffer not following register while off");
  chk_off_polarity: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && !ctrl0.module_on) |=> out_pins == $past(ctrl1.polarity))
    else $error("outputs not at inactive level while off");
  chk_level_rise: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && ctrl0.module_on && state == ST_IDLE && level_rise)
    |=> state == ST_RISE_DB)
    else $error("level source did not give immediate rising event");
  chk_edge_phase: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && ctrl0.module_on && state == ST_IDLE && !level_rise && edge_rise)
    |=> state == ST_PHASE)
    else $error("edge source did not start phase delay");
  chk_no_source: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && state == ST_IDLE && rise_src_en == REG_RESET)
    |=> state == ST_IDLE)
    else $error("rising event with no source enabled");
  chk_sys_tick: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && ctrl0.clock_source_sel == CS_SYS) |=> gen_tick)
    else $error("system clock select gave no tick");
  chk_fwd_mode: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && ctrl0.module_on && ctrl0.output_mode_sel == MD_FWD)
    |=> out_pins[0] == !$past(ctrl1.polarity[0]))
    else $error("forward bridge output A not active");

endmodule : cog_core
`default_nettype wire

// *** sim/cog_event_src_model.sv ***
// Purpose: far-side event sources that feed the generator
// Assumes: commands change just after a pclk edge
// Notes:   LAG adds cycles of delay to model a slow source
`timescale 1ns/1ps
`default_nettype none
module cog_event_src_model #(
  parameter int LAG = 2
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [6:0] cmd_src,
  input  wire logic       cmd_fall,
  output logic [6:0]      event_src,
  output logic            fall_event
);
  // ****************************************
  // source delay line
  // ****************************************
  logic [7:0] pipe [LAG];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < LAG; i++) pipe[i] <= 8'h00;
    end
    else
    begin
      pipe[0] <= {cmd_fall, cmd_src};
      for (int i = 1; i < LAG; i++) pipe[i] <= pipe[i-1];
    end
  end

  assign event_src  = pipe[LAG-1][6:0];
  assign fall_event = pipe[LAG-1][7];
endmodule : cog_event_src_model
`default_nettype wire

// *** sim/complementary_output_control_bench.sv ***
// Purpose: self-checking bench of the generator control block
// Assumes: one wait state on the register bus
// Notes:   dead-time sources compared by measured latency
`timescale 1ns/1ps
`default_nettype none
module complementary_output_control_bench;
  import cog_pkg::*;
  typedef struct { logic [7:0] a; logic [31:0] d; logic [7:0] e; } row_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        hf_osc_tick, fall_event, cmd_fall;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [6:0]  event_src, cmd_src;
  logic [3:0]  out_pins, idle, act;
  logic [1:0]  hcnt;
  logic        e;
  int          n_fail, samples_checked, lat, l_sys, l_ins, l_hf, l_a;
  // last row puts polarity back to zero before the output tests
  row_t rows[8] = '{'{ADDR_CTRL0, 32'h15, 8'h15}, '{ADDR_CTRL0, 32'h20, 8'h00},
    '{ADDR_CTRL1, 32'hff, 8'hcf}, '{ADDR_CTRL1, 32'hffff_ff35, 8'h05},
    '{ADDR_RISE_EN, 32'hff, 8'h7f}, '{ADDR_RISE_EN, 32'h80, 8'h00},
    '{ADDR_CTRL0, 32'h00, 8'h00}, '{ADDR_CTRL1, 32'h00, 8'h00}};

  cog_core u_dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .event_src(event_src), .fall_event(fall_event),
    .hf_osc_tick(hf_osc_tick), .out_pins(out_pins));
  cog_event_src_model u_src (.pclk(pclk), .presetn(presetn),
    .cmd_src(cmd_src), .cmd_fall(cmd_fall), .event_src(event_src),
    .fall_event(fall_event));

  // ****************************************
  // clock, oscillator tick, helpers
  // ****************************************
  always #2.5 pclk = ~pclk;

  always @(posedge pclk)
  begin
    hcnt <= (hcnt == 2'd2) ? 2'd0 : hcnt + 2'd1;
    hf_osc_tick <= (hcnt == 2'd2);
  end

  task automatic summarize;
    $display("checks=%0d errors=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s exp=%h seen=%h", nm, exp, seen);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      n_fail++;
      summarize();
    end
  endtask : apb

  task automatic rdchk(input string nm, input logic [7:0] a,
                       input logic [7:0] x);
    apb(1'b0, a, 32'h0);
    check(nm, r, {24'h0, x});
  endtask : rdchk

  // raise one source, time the outputs, then end the pulse
  task automatic fire(input int b, input int bound);
    int n;
    lat = -1;
    cmd_src[b] <= 1'b1;
    for (n = 0; n < bound && lat < 0; n++)
    begin
      @(posedge pclk);
      if (out_pins !== idle)
      begin
        lat = n;
        act = out_pins;
      end
    end
    cmd_src[b] <= 1'b0;
    cmd_fall   <= 1'b1;
    @(posedge pclk);
    for (n = 0; n < 200 && out_pins !== idle; n++) @(posedge pclk);
    check("fall", 32'(out_pins), 32'(idle));
    cmd_fall <= 1'b0;
    repeat (30) @(posedge pclk);
  endtask : fire

  initial
  begin
    #500000;
    n_fail++;
    summarize();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    {pclk, presetn, psel, penable, pwrite, cmd_fall, hf_osc_tick} = '0;
    {paddr, pwdata, cmd_src, idle, hcnt} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("ctrl0_rst", ADDR_CTRL0, REG_RESET);
    rdchk("ctrl1_rst", ADDR_CTRL1, REG_RESET);
    rdchk("rise_en_rst", ADDR_RISE_EN, REG_RESET);
    foreach (rows[i])
    begin
      apb(1'b1, rows[i].a, rows[i].d);
      rdchk("row", rows[i].a, rows[i].e);
    end
    // only legal codes are written
    for (int m = 0; m < 6; m++)
    begin
      apb(1'b1, ADDR_CTRL0, 32'(8'h08 | m));
      rdchk("mode", ADDR_CTRL0, 8'(8'h08 | m));
    end
    for (int c = 0; c < 3; c++)
    begin
      apb(1'b1, ADDR_CTRL0, 32'(c << 3));
      rdchk("clk_sel", ADDR_CTRL0, 8'(c << 3));
    end
    apb(1'b0, 8'h20, 32'h0);
    check("unmapped_err", 32'(e), 32'h1);
    check("unmapped_data", r, 32'h0);
    apb(1'b1, 8'h02, 32'hff);
    check("unaligned_err", 32'(e), 32'h1);
    apb(1'b1, ADDR_DB_RISE, 32'h08);
    apb(1'b1, ADDR_RISE_EN, 32'h02);
    apb(1'b1, ADDR_CTRL0, 32'h08);
    fire(1, 40);
    check("off", 32'(lat < 0), 32'h1);
    apb(1'b1, ADDR_CTRL0, 32'h88);
    fire(1, 100);
    l_sys = lat;
    check("direct_load", 32'(l_sys >= 8), 32'h1);
    check("steer_on", 32'(act), 32'hf);
    apb(1'b1, ADDR_CTRL1, 32'h0a);
    idle = 4'ha;
    repeat (2) @(posedge pclk);
    check("pol_idle", 32'(out_pins), 32'ha);
    fire(1, 100);
    check("pol_act", 32'(act), 32'h5);
    fire(2, 40);
    check("src_off", 32'(lat < 0), 32'h1);
    apb(1'b1, ADDR_RISE_EN, 32'h05);
    fire(0, 100);
    check("pin_src", 32'(lat >= 0), 32'h1);
    fire(2, 100);
    check("or_src", 32'(lat >= 0), 32'h1);
    apb(1'b1, ADDR_CTRL0, 32'h80);
    fire(2, 200);
    l_ins = lat;
    check("instr_clk", 32'(l_ins > l_sys), 32'h1);
    apb(1'b1, ADDR_CTRL0, 32'h90);
    fire(2, 200);
    l_hf = lat;
    check("hf_clk", 32'(l_hf > l_sys && l_hf < l_ins), 32'h1);
    apb(1'b1, ADDR_CTRL1, 32'h8a);
    apb(1'b1, ADDR_CTRL0, 32'h80);
    fire(2, 200);
    check("chain", 32'(lat >= 0 && lat < l_ins), 32'h1);
    apb(1'b1, ADDR_CTRL1, 32'h4a);
    rdchk("fall_src", ADDR_CTRL1, 8'h4a);
    apb(1'b1, ADDR_CTRL0, 32'h88);
    apb(1'b1, ADDR_DB_RISE, 32'h20);
    fire(2, 200);
    l_a = lat;
    check("held_count", 32'(l_a), 32'(l_sys));
    apb(1'b1, ADDR_CTRL0, 32'hc8);
    rdchk("ld_pend", ADDR_CTRL0, 8'hc8);
    fire(2, 200);
    rdchk("ld_clear", ADDR_CTRL0, 8'h88);
    fire(2, 200);
    check("new_count", 32'(lat > l_sys), 32'h1);
    // bridge and push-pull modes: idle level changes with the mode, let it settle first
    apb(1'b1, ADDR_CTRL0, 32'h8a);
    idle = 4'hb;
    repeat (2) @(posedge pclk);
    fire(2, 200);
    check("fwd_act", 32'(act), 32'h3);
    apb(1'b1, ADDR_CTRL0, 32'h8b);
    idle = 4'he;
    repeat (2) @(posedge pclk);
    fire(2, 200);
    check("rev_act", 32'(act), 32'hc);
    apb(1'b1, ADDR_CTRL0, 32'h8c);
    idle = 4'h0;
    repeat (2) @(posedge pclk);
    fire(2, 200);
    check("half_db", 32'(act), 32'ha);
    apb(1'b1, ADDR_CTRL0, 32'h8d);
    idle = 4'ha;
    repeat (2) @(posedge pclk);
    fire(2, 200);
    r = 32'(act);
    fire(2, 200);
    check("pp_alt", 32'(act) ^ r, 32'h3);
    apb(1'b1, ADDR_RISE_MODE, 32'h02);
    apb(1'b1, ADDR_RISE_EN, 32'h00);
    cmd_src[1] <= 1'b1;
    apb(1'b1, ADDR_RISE_EN, 32'h02);
    repeat (30) @(posedge pclk);
    check("edge_hold", 32'(out_pins), 32'(idle));
    cmd_src[1] <= 1'b0;
    repeat (5) @(posedge pclk);
    fire(1, 200);
    check("edge_fire", 32'(lat >= 0), 32'h1);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("ctrl0_rst2", ADDR_CTRL0, REG_RESET);
    rdchk("ctrl1_rst2", ADDR_CTRL1, REG_RESET);
    summarize();
  end
endmodule : complementary_output_control_bench
`default_nettype wire
